//--- bench/audio_sink_model.sv
// Far-side audio device model driving frame and bit clocks in slave runs
`timescale 1ns/10ps
`default_nettype none
module audio_sink_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bench control
	input wire logic frameTick,
	input wire logic [1:0] edgeCount,
	input wire logic slaveMode,
	// Clock pins toward the port
	output logic frameClockDrive,
	output logic bitClockDrive,
	output logic driveEn
);
	logic [8:0] cnt_q;
	logic [1:0] edges_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 9'h1FF;
			edges_q <= 2'h0;
		end else if (frameTick) begin
			cnt_q <= 9'h000;
			edges_q <= edgeCount;
		end else if (cnt_q != 9'h1FF) begin
			cnt_q <= cnt_q + 9'h001;
		end
	end

	assign driveEn = slaveMode;
	// Parked low between frames, so idle time adds no active edges
	always_comb begin
		case (edges_q)
			2'h1: frameClockDrive = cnt_q < 9'h096;
			2'h2: frameClockDrive = (cnt_q < 9'h03C) || (cnt_q >= 9'h04B && cnt_q < 9'h087);
			default: frameClockDrive = 1'b0;
		endcase
	end
	// Bursty bit clock: 64 periods at the start of each frame, then stopped
	assign bitClockDrive = (cnt_q < 9'h080) ? cnt_q[0] : 1'b0;
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the serial audio output port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk, rst, psel, penable, pwrite, preambleStrobe, subValid, subRight;
	logic frameTick, slaveMode, pready, pslverr, rdErr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic [1:0] preambleType, edgeCount;
	logic lrcOut, lrcOe, bclkOut, bclkOe, sdata, blkOut, gpoOut, irqOut;
	logic lrcDrv, bclkDrv, sinkEn, lrcWire, bclkWire;
	int errors, tests_run, ones, rises, riseAt;

	// Board pull-downs hold released clock lines low
	assign lrcWire = lrcOe ? lrcOut : (sinkEn ? lrcDrv : 1'b0);
	assign bclkWire = bclkOe ? bclkOut : (sinkEn ? bclkDrv : 1'b0);

	serial_audio_output_port #(.BCLK_HALF(2)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.preambleStrobe(preambleStrobe), .preambleType(preambleType), .subValid(subValid),
		.subRight(subRight), .subAudio(24'hFFFFFF), .subV(1'b0), .subU(1'b0), .subC(1'b0),
		.outputFrameClockIn(lrcWire), .outputFrameClockOut(lrcOut), .outputFrameClockOe(lrcOe),
		.outputBitClockIn(bclkWire), .outputBitClockOut(bclkOut), .outputBitClockOe(bclkOe),
		.serialDataOut(sdata), .blockStartOutput(blkOut), .generalOutputPin(gpoOut),
		.irqOut(irqOut)
	);

	audio_sink_model u_sink (
		.sys_clk(sys_clk), .rst(rst), .frameTick(frameTick), .edgeCount(edgeCount),
		.slaveMode(slaveMode), .frameClockDrive(lrcDrv), .bitClockDrive(bclkDrv),
		.driveEn(sinkEn)
	);

	always #4 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 20) errors++;
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// One decoder frame of 300 cycles: preamble, left, Y preamble, right
	task automatic frame(input logic isZ, input logic [1:0] edgesIn);
		logic pl, pb;
		pl = lrcOut;
		pb = bclkOut;
		ones = 0;
		rises = 0;
		riseAt = -1;
		for (int i = 0; i < 300; i++) begin
			preambleStrobe <= (i == 0) || (i == 20);
			preambleType <= (i == 20) ? sao_pkg::PRE_Y : (isZ ? sao_pkg::PRE_Z : sao_pkg::PRE_X);
			subValid <= (i == 10) || (i == 30);
			subRight <= (i == 30);
			frameTick <= (i == 0);
			edgeCount <= edgesIn;
			@(posedge sys_clk);
			if (sdata === 1'b1) ones++;
			if (bclkOut === 1'b1 && pb === 1'b0) rises++;
			if (lrcOut === 1'b1 && pl === 1'b0 && riseAt < 0) riseAt = i;
			pl = lrcOut;
			pb = bclkOut;
		end
	endtask

	task automatic results;
		$display("Checks run %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		results();
	end

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, preambleStrobe, subValid, subRight, frameTick, slaveMode} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		preambleType = 2'h0;
		edgeCount = 2'h0;
		errors = 0;
		tests_run = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		check({31'h0, rdErr}, 32'h1);
		for (int r = 0; r < 4; r++) begin
			// Each word resolution code reads back as written, AES3 format included
			apb(1'b1, sao_pkg::ADDR_FMT, 32'(r << 4) | 32'h80);
			apb(1'b0, sao_pkg::ADDR_FMT, 32'h0);
			check(rdData, 32'(r << 4) | 32'h80);
		end
		// Master, 24-bit left justified, block start routed out
		apb(1'b1, sao_pkg::ADDR_FMT, 32'h80);
		apb(1'b1, sao_pkg::ADDR_CTRL1, 32'h2);
		check({30'h0, lrcOe, bclkOe}, 32'h3);
		for (int k = 0; k < 20; k++) begin
			frame(k == 0, 2'h0);
			check(32'(rises), 32'd64);
			check({31'h0, blkOut}, 32'(k >= 2 && k <= 17));
			check({31'h0, gpoOut}, 32'(k >= 2 && k <= 17));
			check(32'(ones > 0), 32'(k >= 3));
		end
		check(32'(riseAt >= 8 && riseAt <= 13), 32'h1);
		apb(1'b1, sao_pkg::ADDR_FMT, 32'hC0);
		frame(1'b0, 2'h0);
		check(32'(rises), 32'd128);
		apb(1'b1, sao_pkg::ADDR_CTRL1, 32'h3);
		frame(1'b0, 2'h0);
		check(32'(ones), 32'd0);
		// Slave runs with the far side owning both clocks
		slaveMode <= 1'b1;
		apb(1'b1, sao_pkg::ADDR_FMT, 32'h00);
		apb(1'b1, sao_pkg::ADDR_MASK, 32'h20);
		check({30'h0, lrcOe, bclkOe}, 32'h0);
		repeat (4) frame(1'b0, 2'h1);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		repeat (3) frame(1'b0, 2'h1);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h0);
		// An interval is judged only SLIP_WAIT_CYC cycles after the preamble that closes it
		repeat (2) frame(1'b0, 2'h0);
		check({31'h0, irqOut}, 32'h1);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h20);
		// Two more empty intervals fall inside the hysteresis hold
		frame(1'b0, 2'h0);
		frame(1'b0, 2'h1);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h0);
		check({31'h0, irqOut}, 32'h0);
		repeat (3) frame(1'b0, 2'h1);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h0);
		repeat (3) frame(1'b0, 2'h2);
		apb(1'b0, sao_pkg::ADDR_ISTAT, 32'h0);
		check(rdData, 32'h20);
		results();
	end
endmodule
`default_nettype wire

//--- hdl/serial_audio_output_port.sv
// Serial audio output port with APB registers and slip/repeat detection
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Master drives frame and bit clocks
// - Slave takes async, gappy external clocks
// - No right justification as slave
// - Mute bit silences data immediately
// - All format options are configurable
// - Resolution 11 gives AES3 direct words
// - Block start on pin or general output
// - Check interval after preamble fixed delay
// - Missed update repeats frame, sets flag
// - Double update drops frame, sets flag
// - One active edge leaves flag alone
// - Sticky flag bit 5, read clears
// - Hysteresis gives one event per crossing
// - Master frame edge near preamble start
// - Master latency three frames
// - Preamble to edge delay fixed figure
// - Slave edge window treats as simultaneous
// - Slave latency whole frames plus offset
// - Block start high 16 frames, after two
module serial_audio_output_port #(
	parameter int FRAME_CYC = sao_pkg::FRAME_CYC,
	parameter int BCLK_HALF = sao_pkg::BCLK_HALF64,
	parameter int LAT = sao_pkg::LAT_FRAMES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoder side
	input wire logic preambleStrobe,
	input wire logic [1:0] preambleType,
	input wire logic subValid,
	input wire logic subRight,
	input wire logic [23:0] subAudio,
	input wire logic subV,
	input wire logic subU,
	input wire logic subC,
	// Serial pins
	input wire logic outputFrameClockIn,
	output logic outputFrameClockOut,
	output logic outputFrameClockOe,
	input wire logic outputBitClockIn,
	output logic outputBitClockOut,
	output logic outputBitClockOe,
	output logic serialDataOut,
	// Status pins
	output logic blockStartOutput,
	output logic generalOutputPin,
	output logic irqOut
);
	localparam int WW = sao_pkg::WORD_W;
	localparam int WIN_CYC = FRAME_CYC * sao_pkg::WIN_PCT / 100;
	localparam int ALIGN_D = sao_pkg::ALIGN_CYC;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	function automatic logic [7:0] wordWidth(input logic [1:0] res);
		case (res)
			sao_pkg::RES_20: return sao_pkg::WIDTH_20;
			sao_pkg::RES_16: return sao_pkg::WIDTH_16;
			sao_pkg::RES_AES: return sao_pkg::WIDTH_AES;
			default: return sao_pkg::WIDTH_24;
		endcase
	endfunction

	function automatic logic pickBit(input logic [WW-1:0] w, input logic [7:0] slot,
			input logic [7:0] start, input logic [7:0] width);
		logic [7:0] pos;
		pos = slot - start;
		if (slot < start || pos >= width) begin
			return 1'b0;
		end
		return w[WW - 1 - int'(pos)];
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		return a == sao_pkg::ADDR_CTRL1 || a == sao_pkg::ADDR_FMT ||
			a == sao_pkg::ADDR_MASK || a == sao_pkg::ADDR_ISTAT;
	endfunction

	// Control registers
	logic portMasterSelect_q, bitClockRateSelect_q, justifySelect_q, firstBitDelay_q;
	logic bitClockPolarity_q, frameClockPolarity_q, outputMuteBit_q, routeToGeneral_q;
	logic [1:0] wordResolutionField_q;
	logic slipMask_q, slipRepeatFlag_q;
	logic wrEn, rdClear, slipEvent;
	logic [31:0] readValue;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);
	assign wrEn = psel & penable & pwrite;
	assign rdClear = psel & penable & ~pwrite & (paddr == sao_pkg::ADDR_ISTAT);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			portMasterSelect_q <= 1'b0;
			bitClockRateSelect_q <= 1'b0;
			wordResolutionField_q <= sao_pkg::RES_24;
			justifySelect_q <= 1'b0;
			firstBitDelay_q <= 1'b0;
			bitClockPolarity_q <= 1'b0;
			frameClockPolarity_q <= 1'b0;
		end else if (wrEn && paddr == sao_pkg::ADDR_FMT) begin
			portMasterSelect_q <= pwdata[sao_pkg::FMT_MASTER];
			bitClockRateSelect_q <= pwdata[sao_pkg::FMT_RATE];
			wordResolutionField_q <= pwdata[sao_pkg::FMT_RES_LSB +: 2];
			justifySelect_q <= pwdata[sao_pkg::FMT_JUST];
			firstBitDelay_q <= pwdata[sao_pkg::FMT_DELAY];
			bitClockPolarity_q <= pwdata[sao_pkg::FMT_BITPOL];
			frameClockPolarity_q <= pwdata[sao_pkg::FMT_FRAMEPOL];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			outputMuteBit_q <= 1'b0;
			routeToGeneral_q <= 1'b0;
			slipMask_q <= 1'b0;
		end else if (wrEn && paddr == sao_pkg::ADDR_CTRL1) begin
			outputMuteBit_q <= pwdata[sao_pkg::CTRL1_MUTE];
			routeToGeneral_q <= pwdata[sao_pkg::CTRL1_ROUTE];
		end else if (wrEn && paddr == sao_pkg::ADDR_MASK) begin
			slipMask_q <= pwdata[sao_pkg::ISTAT_SLIP];
		end
	end

	always_comb begin
		readValue = '0;
		case (paddr)
			sao_pkg::ADDR_CTRL1: begin
				readValue[sao_pkg::CTRL1_MUTE] = outputMuteBit_q;
				readValue[sao_pkg::CTRL1_ROUTE] = routeToGeneral_q;
			end
			sao_pkg::ADDR_FMT: begin
				readValue[sao_pkg::FMT_MASTER] = portMasterSelect_q;
				readValue[sao_pkg::FMT_RATE] = bitClockRateSelect_q;
				readValue[sao_pkg::FMT_RES_LSB +: 2] = wordResolutionField_q;
				readValue[sao_pkg::FMT_JUST] = justifySelect_q;
				readValue[sao_pkg::FMT_DELAY] = firstBitDelay_q;
				readValue[sao_pkg::FMT_BITPOL] = bitClockPolarity_q;
				readValue[sao_pkg::FMT_FRAMEPOL] = frameClockPolarity_q;
			end
			sao_pkg::ADDR_MASK: readValue[sao_pkg::ISTAT_SLIP] = slipMask_q;
			sao_pkg::ADDR_ISTAT: readValue[sao_pkg::ISTAT_SLIP] = slipRepeatFlag_q;
			default: readValue = '0;
		endcase
	end

	// Read data captured in the setup phase so it comes from a flop
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= readValue;
		end
	end

	// Event wins over a clear in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slipRepeatFlag_q <= 1'b0;
		end else if (slipEvent) begin
			slipRepeatFlag_q <= 1'b1;
		end else if (rdClear) begin
			slipRepeatFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= slipRepeatFlag_q & slipMask_q;
		end
	end

	// Sample pipeline; each pair push is one buffer update
	logic [WW-1:0] leftHold_q;
	logic [2*WW-1:0] pipe_q [LAT];
	logic zFrame_q, pushEv, preXZ;
	assign pushEv = subValid & subRight;
	assign preXZ = preambleStrobe && preambleType != sao_pkg::PRE_Y;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			zFrame_q <= 1'b0;
			leftHold_q <= '0;
		end else begin
			if (preambleStrobe) begin
				zFrame_q <= preambleType == sao_pkg::PRE_Z;
			end
			if (subValid && !subRight) begin
				// Block start marker takes the parity position
				leftHold_q <= {subAudio, subV, subU, subC, zFrame_q};
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < LAT; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (pushEv) begin
			pipe_q[0] <= {leftHold_q, subAudio, subV, subU, subC, 1'b0};
			for (int i = 1; i < LAT; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	// Pin synchronisers
	logic [1:0] fcSync_q, bcSync_q;
	logic fcPrev_q, bcPrev_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fcSync_q <= '0;
			bcSync_q <= '0;
			fcPrev_q <= 1'b0;
			bcPrev_q <= 1'b0;
		end else begin
			fcSync_q <= {fcSync_q[0], outputFrameClockIn};
			bcSync_q <= {bcSync_q[0], outputBitClockIn};
			fcPrev_q <= fcSync_q[1];
			bcPrev_q <= bcSync_q[1];
		end
	end

	logic slvFrameEdge, slvHalf, slvShift;
	assign slvFrameEdge = fcSync_q[1] != fcPrev_q;
	assign slvHalf = ~(fcSync_q[1] ^ frameClockPolarity_q);
	// A stalled bit clock just stalls the slot counter
	assign slvShift = (bcSync_q[1] != bcPrev_q) && (bcSync_q[1] == bitClockPolarity_q);

	// Master clock engine
	sao_pkg::master_state_t mState_q;
	logic [7:0] alignCnt_q, slot_q, halfLen, startSlot, width;
	logic [15:0] div_q, halfDiv;
	logic bclk_q, half_q, mStart, mShift, frameEdge, activeEdge, shiftEv, justifyEff;

	assign halfLen = bitClockRateSelect_q ? sao_pkg::SLOTS_FAST : sao_pkg::SLOTS_SLOW;
	assign halfDiv = bitClockRateSelect_q ? 16'(BCLK_HALF / 2) : 16'(BCLK_HALF);
	assign mStart = mState_q == sao_pkg::M_ALIGN && alignCnt_q == '0;
	assign mShift = mState_q == sao_pkg::M_RUN && div_q == halfDiv - 16'h0001 && bclk_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mState_q <= sao_pkg::M_IDLE;
			alignCnt_q <= '0;
		end else if (!portMasterSelect_q) begin
			mState_q <= sao_pkg::M_IDLE;
		end else if (preXZ) begin
			mState_q <= sao_pkg::M_ALIGN;
			alignCnt_q <= 8'(ALIGN_D - 1);
		end else begin
			case (mState_q)
				sao_pkg::M_ALIGN: begin
					if (mStart) begin
						mState_q <= sao_pkg::M_RUN;
					end else begin
						alignCnt_q <= alignCnt_q - 8'h01;
					end
				end
				sao_pkg::M_RUN: begin
					if (mShift && half_q && slot_q == halfLen - 8'h01) begin
						mState_q <= sao_pkg::M_IDLE;
					end
				end
				default: mState_q <= sao_pkg::M_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			bclk_q <= 1'b0;
		end else if (mStart || mState_q != sao_pkg::M_RUN) begin
			div_q <= '0;
			bclk_q <= 1'b0;
		end else if (div_q == halfDiv - 16'h0001) begin
			div_q <= '0;
			bclk_q <= ~bclk_q;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	assign frameEdge = portMasterSelect_q ? mStart : slvFrameEdge;
	assign activeEdge = portMasterSelect_q ? mStart : (slvFrameEdge && !slvHalf);
	assign shiftEv = portMasterSelect_q ? mShift : slvShift;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slot_q <= '0;
			half_q <= 1'b1;
		end else if (frameEdge) begin
			slot_q <= '0;
			half_q <= portMasterSelect_q ? 1'b0 : slvHalf;
		end else if (shiftEv) begin
			if (portMasterSelect_q && slot_q == halfLen - 8'h01) begin
				slot_q <= '0;
				half_q <= 1'b1;
			end else if (slot_q != sao_pkg::SLOT_MAX) begin
				slot_q <= slot_q + 8'h01;
			end
		end
	end

	assign outputFrameClockOe = portMasterSelect_q;
	assign outputBitClockOe = portMasterSelect_q;
	assign outputFrameClockOut = half_q ? frameClockPolarity_q : ~frameClockPolarity_q;
	assign outputBitClockOut = bclk_q ^ bitClockPolarity_q;

	// Word latch at the active frame edge
	logic [WW-1:0] wordL_q, wordR_q;
	logic [11:0] sinceEdge_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sinceEdge_q <= '0;
		end else if (activeEdge) begin
			sinceEdge_q <= '0;
		end else if (sinceEdge_q != '1) begin
			sinceEdge_q <= sinceEdge_q + 12'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wordL_q <= '0;
			wordR_q <= '0;
		end else if (activeEdge) begin
			{wordL_q, wordR_q} <= pipe_q[LAT-1];
		end else if (!portMasterSelect_q && pushEv && sinceEdge_q < 12'(WIN_CYC)) begin
			// Update just after the edge counts as simultaneous with it
			{wordL_q, wordR_q} <= {leftHold_q, subAudio, subV, subU, subC, 1'b0};
		end
	end

	assign justifyEff = justifySelect_q & portMasterSelect_q;
	assign width = wordWidth(wordResolutionField_q);
	assign startSlot = justifyEff ? halfLen - width : {7'h00, firstBitDelay_q};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serialDataOut <= 1'b0;
		end else if (outputMuteBit_q) begin
			serialDataOut <= 1'b0;
		end else begin
			serialDataOut <= pickBit(half_q ? wordR_q : wordL_q, slot_q, startSlot, width);
		end
	end

	// Slip/repeat check between X/Z preambles
	logic [1:0] edgeCnt_q, edgesCap_q, hold_q;
	logic [7:0] wait_q;
	logic waiting_q, primed_q, validCap_q, evalNow;
	assign evalNow = waiting_q && wait_q == '0;
	assign slipEvent = evalNow && validCap_q && !portMasterSelect_q && hold_q == '0 &&
		edgesCap_q != 2'h1;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			edgeCnt_q <= '0;
			edgesCap_q <= '0;
			wait_q <= '0;
			waiting_q <= 1'b0;
			primed_q <= 1'b0;
			validCap_q <= 1'b0;
		end else if (preXZ) begin
			edgesCap_q <= edgeCnt_q;
			edgeCnt_q <= activeEdge ? 2'h1 : 2'h0;
			wait_q <= 8'(sao_pkg::SLIP_WAIT_CYC);
			waiting_q <= 1'b1;
			primed_q <= 1'b1;
			validCap_q <= primed_q;
		end else begin
			if (activeEdge && edgeCnt_q != sao_pkg::EDGE_SAT) begin
				edgeCnt_q <= edgeCnt_q + 2'h1;
			end
			if (evalNow) begin
				waiting_q <= 1'b0;
			end else if (waiting_q) begin
				wait_q <= wait_q - 8'h01;
			end
		end
	end

	// Jitter around the crossing point would otherwise fire repeatedly
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_q <= '0;
		end else if (slipEvent) begin
			hold_q <= sao_pkg::HYST_FRAMES;
		end else if (evalNow && hold_q != '0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// Channel-status block start
	logic [7:0] blkCnt_q;
	logic seenZ_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blkCnt_q <= '0;
			seenZ_q <= 1'b0;
		end else if (preambleStrobe && preambleType == sao_pkg::PRE_Z) begin
			blkCnt_q <= '0;
			seenZ_q <= 1'b1;
		end else if (preambleStrobe && preambleType == sao_pkg::PRE_X &&
				blkCnt_q != sao_pkg::SLOT_MAX) begin
			blkCnt_q <= blkCnt_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blockStartOutput <= 1'b0;
			generalOutputPin <= 1'b0;
		end else begin
			blockStartOutput <= seenZ_q && blkCnt_q >= sao_pkg::BLK_RISE &&
				blkCnt_q < sao_pkg::BLK_RISE + sao_pkg::BLK_HIGH;
			generalOutputPin <= routeToGeneral_q && seenZ_q && blkCnt_q >= sao_pkg::BLK_RISE &&
				blkCnt_q < sao_pkg::BLK_RISE + sao_pkg::BLK_HIGH;
		end
	end

	a_mute_silence: assert property (outputMuteBit_q |=> !serialDataOut)
		else $error("data not silent while muted");
	a_slave_pins: assert property (!portMasterSelect_q |-> !outputFrameClockOe && !outputBitClockOe)
		else $error("clock pins driven in slave mode");
	a_master_clock: assert property (portMasterSelect_q && preXZ |-> ##[ALIGN_D:ALIGN_D] mStart ##2
		(outputFrameClockOut == ~frameClockPolarity_q))
		else $error("master frame clock not started after preamble");
	a_rj_slave: assert property (!portMasterSelect_q && justifySelect_q |-> startSlot == {7'h00, firstBitDelay_q})
		else $error("right justification used as slave");
	a_flag_sticky: assert property (slipRepeatFlag_q && !rdClear |=> slipRepeatFlag_q)
		else $error("slip flag dropped without read");
	a_flag_clear: assert property (rdClear && !slipEvent |=> !slipRepeatFlag_q)
		else $error("slip flag not cleared by read");
	a_slip_set: assert property (evalNow && validCap_q && !portMasterSelect_q && hold_q == 2'h0 &&
		edgesCap_q == 2'h0 |=> slipRepeatFlag_q)
		else $error("dropped frame not flagged");
	a_no_event: assert property (evalNow && edgesCap_q == 2'h1 && !rdClear |=>
		slipRepeatFlag_q == $past(slipRepeatFlag_q))
		else $error("flag changed with a single edge");
	a_hyst_once: assert property (slipEvent |=> !slipEvent [*8])
		else $error("slip events repeat back to back");
	a_block_low: assert property (preambleStrobe && preambleType == sao_pkg::PRE_Z |-> ##2 !blockStartOutput)
		else $error("block start not low after Z");
	a_irq_raise: assert property (slipRepeatFlag_q && slipMask_q |=> irqOut)
		else $error("interrupt missing for unmasked flag");
endmodule
`default_nettype wire

//--- shared/sao_pkg.sv
// Constants shared by the serial audio output port
package sao_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL1 = 8'h01;
	localparam logic [7:0] IDX_FMT = 8'h05;
	localparam logic [7:0] IDX_MASK = 8'h0B;
	localparam logic [7:0] IDX_ISTAT = 8'h0D;
	localparam logic [11:0] ADDR_CTRL1 = {2'h0, IDX_CTRL1, 2'h0};
	localparam logic [11:0] ADDR_FMT = {2'h0, IDX_FMT, 2'h0};
	localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
	localparam logic [11:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
	// Control 1 fields
	localparam int CTRL1_MUTE = 0;
	localparam int CTRL1_ROUTE = 1;
	// Format fields
	localparam int FMT_FRAMEPOL = 0;
	localparam int FMT_BITPOL = 1;
	localparam int FMT_DELAY = 2;
	localparam int FMT_JUST = 3;
	localparam int FMT_RES_LSB = 4;
	localparam int FMT_RATE = 6;
	localparam int FMT_MASTER = 7;
	// Interrupt status and mask field
	localparam int ISTAT_SLIP = 5;
	// Word resolution codes and widths
	localparam logic [1:0] RES_24 = 2'h0;
	localparam logic [1:0] RES_20 = 2'h1;
	localparam logic [1:0] RES_16 = 2'h2;
	localparam logic [1:0] RES_AES = 2'h3;
	localparam int WORD_W = 28;
	localparam logic [7:0] WIDTH_24 = 8'h18;
	localparam logic [7:0] WIDTH_20 = 8'h14;
	localparam logic [7:0] WIDTH_16 = 8'h10;
	localparam logic [7:0] WIDTH_AES = 8'h1C;
	// Bit slots per channel half
	localparam logic [7:0] SLOTS_SLOW = 8'h20;
	localparam logic [7:0] SLOTS_FAST = 8'h40;
	localparam logic [7:0] SLOT_MAX = 8'hFF;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int CLK_HZ = 125000000;
	localparam int FS_HZ = 48000;
	localparam int MCLK_RATIO = 256;
	localparam int FRAME_CYC = CLK_HZ / FS_HZ;
	localparam int BCLK_HALF64 = CLK_HZ / (FS_HZ * 64 * 2);
	localparam int ALIGN_NS = 78;
	localparam int ALIGN_CYC = (ALIGN_NS * CLK_MHZ / 1000 < 1) ? 1 : ALIGN_NS * CLK_MHZ / 1000;
	localparam int SLIP_WAIT_PERIODS = 4;
	localparam int SLIP_WAIT_CYC = SLIP_WAIT_PERIODS * CLK_HZ / (MCLK_RATIO * FS_HZ);
	localparam int WIN_PCT = 28;
	localparam int LAT_FRAMES = 3;
	localparam logic [7:0] BLK_RISE = 8'h02;
	localparam logic [7:0] BLK_HIGH = 8'h10;
	localparam logic [1:0] HYST_FRAMES = 2'h2;
	localparam logic [1:0] EDGE_SAT = 2'h2;
	// Preamble kinds from the decoder
	typedef enum logic [1:0] {PRE_Z = 2'b00, PRE_X = 2'b01, PRE_Y = 2'b10} preamble_t;
	// Master clock engine
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_ALIGN = 2'b01, M_RUN = 2'b10} master_state_t;
endpackage
